// >>> core/plnp_pin_logic.v
// Pin logic for the four low pins of an 8-bit bidirectional port
`timescale 1ns/100ps
//
// Contract
// RQ1: Direction bit 1 makes pin an input; reads return its level.
// RQ2: Direction bit 0 drives latch onto pin; analog select leaves it alone.
// RQ3: Weak pull-up on input pins only while shared pull-up disable bit clear.
// RQ4: Analog-selected pin has its digital input path disabled.
// RQ5: After power-on reset all four pins are analog inputs.
// RQ6: Software sets analog select bits before trusting digital reads.
// RQ7: Debug enabled disables every other function on its pins.
// RQ8: Parallel byte enable and address outputs override the direction bit.
// RQ9: Pin is remap input when direction 1, remap output when 0.
// RQ10: Lowest pin feeds external interrupt 0 via Schmitt buffer if input.
// RQ11: Pull-up is turned off whenever the pin is an output.
// RQ12: All weak pull-ups are disabled on power-on reset.
// RQ13: Pins in analog default read back as zero.
// RQ14: One analog select bit per pin gates input; reset selects analog.
//
`include "plnp_regs.vh"

module plnp_pin_logic #(
  parameter PINS   = `PLNP_PINS,
  parameter DBG_MASK = 4'h0
) (
  input  wire                    mclk,
  input  wire                    rstn,
  input  wire                    ce,
  // Register port
  input  wire [`PLNP_ADDR_W-1:0] reg_addr,
  input  wire [`PLNP_DATA_W-1:0] reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [`PLNP_DATA_W-1:0] reg_rdata_r,
  // Pad side
  input  wire [PINS-1:0]         pad_in,
  output reg  [PINS-1:0]         pad_out_r,
  output reg  [PINS-1:0]         pad_oe_r,
  output reg  [PINS-1:0]         pad_pullup_r,
  output reg  [PINS-1:0]         pad_analog_r,
  // Debug override
  input  wire                    in_circuit_debug,
  // Parallel port overrides
  input  wire                    parallel_byte_enable_en,
  input  wire                    parallel_byte_enable,
  input  wire                    parallel_addr_en,
  input  wire                    parallel_addr_bit3,
  input  wire                    parallel_addr_bit2,
  // Remappable peripheral pins
  input  wire [PINS-1:0]         remap_out_sel,
  input  wire [PINS-1:0]         remap_out_data,
  output reg  [PINS-1:0]         remap_in_r,
  // External interrupt 0 input
  output reg                     ext_irq_zero_input_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Software visible state

  reg [PINS-1:0] output_latch_r;
  reg [PINS-1:0] pin_direction_bit_r;
  reg [PINS-1:0] analog_select_reg_r;
  reg            pullup_disable_n_r;

  // Pins held by the debug function
  wire [PINS-1:0] dbg_hold;

  // Digital input after analog and debug gating
  wire [PINS-1:0] dig_in;

  // Next values of the pad outputs
  reg  [PINS-1:0] pad_out_nxt;
  reg  [PINS-1:0] pad_oe_nxt;
  reg  [PINS-1:0] pad_pullup_nxt;

  // Read mux output
  reg  [`PLNP_DATA_W-1:0] rdata_nxt;

  // Per-pin override flags for the parallel port
  reg  [PINS-1:0] par_en;
  reg  [PINS-1:0] par_val;

  // Write enables, one per writable register; the input register has none
  wire            wr_latch;
  wire            wr_dir;
  wire            wr_ansel;
  wire            wr_ctrl;

  // Register images as software reads them; upper bits read zero
  wire [`PLNP_DATA_W-1:0] img_input;
  wire [`PLNP_DATA_W-1:0] img_latch;
  wire [`PLNP_DATA_W-1:0] img_dir;
  wire [`PLNP_DATA_W-1:0] img_ansel;
  reg  [`PLNP_DATA_W-1:0] img_ctrl;

  // Next values of the analog connection and the peripheral inputs
  wire [PINS-1:0] pad_analog_nxt;
  wire [PINS-1:0] remap_in_nxt;
  wire            ext_irq_zero_input_nxt;

  // Loop index
  integer i;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Widen a nibble to the register data width, upper bits read zero
  function [`PLNP_DATA_W-1:0] plnp_widen;
    input [PINS-1:0] nib;
    begin
      plnp_widen = {{(`PLNP_DATA_W-PINS){1'b0}}, nib};
    end
  endfunction

  // Write strobe decode for one offset
  function plnp_hit;
    input                    strobe;
    input [`PLNP_ADDR_W-1:0] addr;
    input [`PLNP_ADDR_W-1:0] ofs;
    begin
      plnp_hit = strobe && (addr == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input gating

  // Debug owns its pins outright; no other function sees them
  assign dbg_hold = in_circuit_debug ? DBG_MASK[PINS-1:0] : {PINS{1'b0}}; // [RQ7]

  // Analog pins read zero; this also covers the power-on default
  assign dig_in = pad_in & analog_select_reg_r & ~dbg_hold; // [RQ4] [RQ13] [RQ14]

  // Analog path connected wherever analog select gates the digital buffer off and debug does not hold the pin
  assign pad_analog_nxt = ~analog_select_reg_r & ~dbg_hold;           // [RQ4]

  // Peripheral inputs see only pins left as digital inputs
  assign remap_in_nxt           = dig_in & pin_direction_bit_r;       // [RQ9]
  assign ext_irq_zero_input_nxt = remap_in_nxt[`PLNP_PIN_IRQ];        // [RQ10]

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  // Unmapped offsets match no enable, so such writes fall away
  assign wr_latch = plnp_hit(reg_wr, reg_addr, `PLNP_OFS_LATCH);
  assign wr_dir   = plnp_hit(reg_wr, reg_addr, `PLNP_OFS_DIR);
  assign wr_ansel = plnp_hit(reg_wr, reg_addr, `PLNP_OFS_ANSEL);
  assign wr_ctrl  = plnp_hit(reg_wr, reg_addr, `PLNP_OFS_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  // Output latch; like every flop here it holds while ce is low
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      output_latch_r <= `PLNP_RST_LATCH;
    end else if (ce && wr_latch) begin
      output_latch_r <= reg_wdata[PINS-1:0];
    end
  end

  // Direction; resets to all inputs so nothing is driven at power-on
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_direction_bit_r <= `PLNP_RST_DIR;                   // [RQ5]
    end else if (ce && wr_dir) begin
      pin_direction_bit_r <= reg_wdata[PINS-1:0];
    end
  end

  // Analog select; resets to analog, software opts pins into digital
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      analog_select_reg_r <= `PLNP_RST_ANSEL;                 // [RQ5] [RQ14]
    end else if (ce && wr_ansel) begin
      analog_select_reg_r <= reg_wdata[PINS-1:0];
    end
  end

  // Shared pull-up disable; set at reset so all pull-ups start off
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pullup_disable_n_r <= `PLNP_RST_PUD_N;                  // [RQ12]
    end else if (ce && wr_ctrl) begin
      pullup_disable_n_r <= reg_wdata[`PLNP_CTRL_PUD_N_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  // Nibble registers widened to the data width
  assign img_input = plnp_widen(dig_in);                        // [RQ1] [RQ13]
  assign img_latch = plnp_widen(output_latch_r);
  assign img_dir   = plnp_widen(pin_direction_bit_r);
  assign img_ansel = plnp_widen(analog_select_reg_r);

  // Control image carries only the pull-up disable bit
  always @* begin
    img_ctrl                       = `PLNP_RST_BYTE;
    img_ctrl[`PLNP_CTRL_PUD_N_BIT] = pullup_disable_n_r;
  end

  // Read mux; unmapped offsets answer zero
  always @* begin
    rdata_nxt = `PLNP_RST_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        `PLNP_OFS_INPUT: rdata_nxt = img_input;                 // [RQ1] [RQ13]
        `PLNP_OFS_LATCH: rdata_nxt = img_latch;
        `PLNP_OFS_DIR:   rdata_nxt = img_dir;
        `PLNP_OFS_ANSEL: rdata_nxt = img_ansel;
        `PLNP_OFS_CTRL:  rdata_nxt = img_ctrl;
        default:         rdata_nxt = `PLNP_RST_BYTE;
      endcase
    end
  end

  // Read data stand for the one cycle after the strobe only
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_r <= `PLNP_RST_BYTE;
    end else if (ce) begin
      reg_rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel port overrides

  // Byte enable on one pin, two address bits on two others
  always @* begin
    par_en  = {PINS{1'b0}};
    par_val = {PINS{1'b0}};
    par_en[`PLNP_PIN_BE]  = parallel_byte_enable_en;          // [RQ8]
    par_val[`PLNP_PIN_BE] = parallel_byte_enable;
    par_en[`PLNP_PIN_A3]  = parallel_addr_en;                 // [RQ8]
    par_val[`PLNP_PIN_A3] = parallel_addr_bit3;
    par_en[`PLNP_PIN_A2]  = parallel_addr_en;                 // [RQ8]
    par_val[`PLNP_PIN_A2] = parallel_addr_bit2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive and pull-up

  // Priority: debug, parallel port, remap output, latch.
  // Analog select is deliberately absent from the drive path.
  always @* begin
    pad_out_nxt    = {PINS{1'b0}};
    pad_oe_nxt     = {PINS{1'b0}};
    pad_pullup_nxt = {PINS{1'b0}};
    for (i = 0; i < PINS; i = i + 1) begin
      if (dbg_hold[i]) begin
        // Pin released to the debug function
        pad_out_nxt[i] = 1'b0;                                // [RQ7]
        pad_oe_nxt[i]  = 1'b0;
      end else if (par_en[i]) begin
        // Direction bit ignored for these outputs
        pad_out_nxt[i] = par_val[i];                          // [RQ8]
        pad_oe_nxt[i]  = 1'b1;
      end else if (pin_direction_bit_r[i] != `PLNP_DIR_IN) begin
        pad_oe_nxt[i] = 1'b1;                                 // [RQ2] [RQ9]
        if (remap_out_sel[i]) begin
          pad_out_nxt[i] = remap_out_data[i];                 // [RQ9]
        end else begin
          pad_out_nxt[i] = output_latch_r[i];                 // [RQ2]
        end
      end else begin
        // Input: high impedance, pull-up only if enabled
        pad_oe_nxt[i]     = 1'b0;                             // [RQ1]
        pad_pullup_nxt[i] = ~pullup_disable_n_r;              // [RQ3]
      end
    end
    // Any driven pin loses its pull-up
    pad_pullup_nxt = pad_pullup_nxt & ~pad_oe_nxt;            // [RQ11]
  end

  // Pad outputs registered; pull-ups off and pins released at reset
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pad_out_r    <= `PLNP_RST_NIB;
      pad_oe_r     <= `PLNP_RST_NIB;
      pad_pullup_r <= `PLNP_RST_NIB;                          // [RQ12]
      pad_analog_r <= ~`PLNP_RST_ANSEL;                       // [RQ5]
    end else if (ce) begin
      pad_out_r    <= pad_out_nxt;
      pad_oe_r     <= pad_oe_nxt;
      pad_pullup_r <= pad_pullup_nxt;
      pad_analog_r <= pad_analog_nxt;                         // [RQ4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral inputs

  // Remap inputs and interrupt 0 see only digital input pins.
  // A registered sample stands in for the Schmitt buffer; glitches
  // shorter than a clock are not filtered, which the user must know.
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      remap_in_r           <= `PLNP_RST_NIB;
      ext_irq_zero_input_r <= 1'b0;
    end else if (ce) begin
      remap_in_r           <= remap_in_nxt;                   // [RQ9]
      ext_irq_zero_input_r <= ext_irq_zero_input_nxt;         // [RQ10]
    end
  end

endmodule

// >>> core/plnp_regs.vh
// Register offsets, field positions and reset values of the low-nibble pin logic
`ifndef PLNP_REGS_VH
`define PLNP_REGS_VH

// Register offsets on the plain register port
`define PLNP_ADDR_W          3
`define PLNP_OFS_INPUT       3'h0
`define PLNP_OFS_LATCH       3'h1
`define PLNP_OFS_DIR         3'h2
`define PLNP_OFS_ANSEL       3'h3
`define PLNP_OFS_CTRL        3'h4

// Data width and pin count
`define PLNP_DATA_W          8
`define PLNP_PINS            4

// Control register field positions
`define PLNP_CTRL_PUD_N_BIT  0

// Reset values
`define PLNP_RST_LATCH       4'h0
`define PLNP_RST_DIR         4'hf
`define PLNP_RST_ANSEL       4'h0
`define PLNP_RST_PUD_N       1'b1
`define PLNP_RST_BYTE        8'h00
`define PLNP_RST_NIB         4'h0

// Pin positions of the fixed overrides
`define PLNP_PIN_IRQ         0
`define PLNP_PIN_BE          1
`define PLNP_PIN_A3          2
`define PLNP_PIN_A2          3

// Direction and analog select encodings
`define PLNP_DIR_IN          1'b1
`define PLNP_ANSEL_DIGITAL   1'b1

`endif

// >>> dv/plnp_pad_model.sv
// Board model of the four pads: chip drive, board source, pull-up or float
`timescale 1ns/100ps
module plnp_pad_model (
  input  wire        mclk,
  input  wire  [3:0] drv_val,
  input  wire  [3:0] drv_oe,
  input  wire  [3:0] pull_on,
  input  wire  [3:0] ext_en,
  input  wire  [3:0] ext_val,
  output logic [3:0] pad_lvl
);
  logic [3:0] flt_r = 4'h0;
  //////////////////////////////////////////////////////////////////////
  // A floating pad wanders every cycle, so no stale level can pass
  always @(posedge mclk) flt_r <= ~flt_r;
  // Chip drive wins, then the board source, then the weak pull-up
  always_comb
    for (int i = 0; i < 4; i++)
      pad_lvl[i] = drv_oe[i] ? drv_val[i] : ext_en[i] ? ext_val[i] : pull_on[i] | flt_r[i];
endmodule

// >>> dv/plnp_pin_logic_properties.sv
// Port checker of the low-nibble pin logic
`timescale 1ns/100ps
`include "plnp_regs.vh"
module plnp_pin_logic_properties #(
  parameter PINS     = 4,
  parameter DBG_MASK = 4'h0
) (
  input wire                    mclk,
  input wire                    rstn,
  input wire                    ce,
  input wire [`PLNP_ADDR_W-1:0] reg_addr,
  input wire [`PLNP_DATA_W-1:0] reg_wdata,
  input wire                    reg_wr,
  input wire                    reg_rd,
  input wire [`PLNP_DATA_W-1:0] reg_rdata_r,
  input wire [PINS-1:0]         pad_out_r,
  input wire [PINS-1:0]         pad_oe_r,
  input wire [PINS-1:0]         pad_pullup_r,
  input wire [PINS-1:0]         pad_analog_r,
  input wire                    in_circuit_debug,
  input wire                    parallel_byte_enable_en,
  input wire                    parallel_byte_enable,
  input wire                    parallel_addr_en,
  input wire                    parallel_addr_bit3,
  input wire                    parallel_addr_bit2,
  input wire [PINS-1:0]         remap_in_r,
  input wire                    ext_irq_zero_input_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////
  // Steps of an input read and of a pull-up disable write
  sequence s_rd_input;
    ce && reg_rd && reg_addr == `PLNP_OFS_INPUT;
  endsequence
  sequence s_pu_off;
    ce && reg_wr && reg_addr == `PLNP_OFS_CTRL && reg_wdata[`PLNP_CTRL_PUD_N_BIT] ##1 ce;
  endsequence
  AST_RST_DEFAULT:
    assert property ($rose(rstn) |-> pad_analog_r == 4'hf && (pad_pullup_r | pad_oe_r) == 4'h0)
    else $error("reset defaults wrong");
  AST_PU_OUT_OFF:
    assert property ((pad_oe_r & pad_pullup_r) == 4'h0) else $error("pull-up on output");
  AST_PU_CTRL:
    assert property (s_pu_off |=> pad_pullup_r == 4'h0) else $error("pull-up not off");
  AST_RD_ANALOG_ZERO:
    assert property (s_rd_input |=> (reg_rdata_r[3:0] & pad_analog_r) == 4'h0)
    else $error("analog pin read high");
  AST_RD_IDLE_ZERO:
    assert property (ce && !reg_rd |=> reg_rdata_r == 8'h00) else $error("stray read data");
  AST_REMAP_DIGITAL:
    assert property ((remap_in_r & pad_analog_r) == 4'h0) else $error("analog pin to remap");
  AST_IRQ_PIN0:
    assert property (ext_irq_zero_input_r == remap_in_r[0]) else $error("irq input mismatch");
  AST_PAR_BE:
    assert property (ce && parallel_byte_enable_en && !in_circuit_debug |=> pad_oe_r[1]
      && pad_out_r[1] == $past(parallel_byte_enable)) else $error("byte enable drive");
  AST_PAR_ADDR:
    assert property (ce && parallel_addr_en && !in_circuit_debug |=> pad_oe_r[3:2] == 2'b11
      && pad_out_r[3] == $past(parallel_addr_bit2) && pad_out_r[2] == $past(parallel_addr_bit3))
    else $error("address drive");
  AST_DEBUG_OFF:
    assert property (ce && in_circuit_debug |=> ((pad_oe_r | pad_pullup_r | remap_in_r)
      & DBG_MASK) == 4'h0) else $error("debug pin still in use");
endmodule
bind plnp_pin_logic plnp_pin_logic_properties #(.PINS(PINS), .DBG_MASK(DBG_MASK)) chk_u (.*);

// >>> dv/plnp_pin_logic_tb.sv
// Self-checking bench of the low-nibble pin logic
`timescale 1ns/100ps
`include "plnp_regs.vh"
module plnp_pin_logic_tb;
  logic       mclk, rstn, ce, reg_wr, reg_rd, in_circuit_debug;
  logic       parallel_byte_enable_en, parallel_byte_enable, parallel_addr_en;
  logic       parallel_addr_bit3, parallel_addr_bit2;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [3:0] remap_out_sel, remap_out_data, ext_en, ext_val;
  wire  [7:0] reg_rdata_r;
  wire  [3:0] pad_in, pad_out_r, pad_oe_r, pad_pullup_r, pad_analog_r, remap_in_r;
  wire        ext_irq_zero_input_r;
  int         failures, checked;
  // Pin 0 doubles as a debug pin so the override is reachable
  plnp_pin_logic #(.DBG_MASK(4'h1)) dut_u (.*);
  plnp_pad_model pad_u (.mclk(mclk), .drv_val(pad_out_r), .drv_oe(pad_oe_r),
    .pull_on(pad_pullup_r), .ext_en(ext_en), .ext_val(ext_val), .pad_lvl(pad_in));
  //////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe, so look just then
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("rdata", exp, reg_rdata_r);
  endtask
  // Outputs lag a register by one edge and a pad by one
  task automatic settle(input string t);
    repeat (3) @(posedge mclk);
    #1 $display("test %s done", t);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk);
    failures++;
    tally_and_finish();
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, reg_wr, reg_rd, in_circuit_debug, parallel_byte_enable_en} = 5'b00000;
    {parallel_byte_enable, parallel_addr_en, parallel_addr_bit3, parallel_addr_bit2} = 4'h0;
    {ce, reg_addr, reg_wdata, remap_out_sel, remap_out_data} = 20'h8_0000;
    {ext_en, ext_val} = 8'hfa;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd(`PLNP_OFS_INPUT, 8'h00);
    rd(`PLNP_OFS_DIR, 8'h0f);
    rd(`PLNP_OFS_ANSEL, 8'h00);
    rd(`PLNP_OFS_CTRL, 8'h01);
    wr(3'h6, 8'hff);
    rd(3'h6, 8'h00);
    settle("defaults");
    chk("analog", 8'h0f, {4'h0, pad_analog_r});
    wr(`PLNP_OFS_ANSEL, 8'h0f);
    settle("digital");
    rd(`PLNP_OFS_INPUT, 8'h0a);
    chk("remap_in", 8'h0a, {4'h0, remap_in_r});
    chk("irq", 8'h00, {7'h0, ext_irq_zero_input_r});
    ext_val <= 4'hd;
    wr(`PLNP_OFS_ANSEL, 8'h07);
    settle("analog gate");
    chk("irq", 8'h01, {7'h0, ext_irq_zero_input_r});
    rd(`PLNP_OFS_INPUT, 8'h05);
    ext_en <= 4'h0;
    wr(`PLNP_OFS_CTRL, 8'h00);
    settle("pull-ups");
    chk("pullup", 8'h0f, {4'h0, pad_pullup_r});
    rd(`PLNP_OFS_INPUT, 8'h07);
    wr(`PLNP_OFS_CTRL, 8'h01);
    settle("pull-ups off");
    chk("pullup", 8'h00, {4'h0, pad_pullup_r});
    wr(`PLNP_OFS_CTRL, 8'h00);
    wr(`PLNP_OFS_LATCH, 8'h05);
    wr(`PLNP_OFS_DIR, 8'h00);
    wr(`PLNP_OFS_ANSEL, 8'h00);
    settle("outputs");
    chk("oe", 8'h0f, {4'h0, pad_oe_r});
    chk("out", 8'h05, {4'h0, pad_out_r});
    chk("pullup", 8'h00, {4'h0, pad_pullup_r});
    rd(`PLNP_OFS_LATCH, 8'h05);
    // A write while the clock enable is low must not land
    ce <= 1'b0;
    wr(`PLNP_OFS_LATCH, 8'h0a);
    ce <= 1'b1;
    settle("frozen");
    rd(`PLNP_OFS_LATCH, 8'h05);
    chk("out", 8'h05, {4'h0, pad_out_r});
    {remap_out_sel, remap_out_data} <= 8'h32;
    settle("remap out");
    chk("out", 8'h06, {4'h0, pad_out_r});
    in_circuit_debug <= 1'b1;
    settle("debug");
    chk("oe", 8'h0e, {4'h0, pad_oe_r});
    in_circuit_debug <= 1'b0;
    wr(`PLNP_OFS_DIR, 8'h0f);
    {parallel_byte_enable_en, parallel_byte_enable, parallel_addr_en} <= 3'b111;
    {parallel_addr_bit3, parallel_addr_bit2} <= 2'b10;
    settle("parallel");
    chk("oe", 8'h0e, {4'h0, pad_oe_r});
    chk("out", 8'h06, {4'h0, pad_out_r & 4'he});
    tally_and_finish();
  end
endmodule
